// file: hw/sppp_pkg.sv
// constants for the shared peripheral port pin block
package sppp_pkg;
   localparam int unsigned CAN_RX_BIT = 0;
   localparam int unsigned CAN_TX_BIT = 1;
   localparam int unsigned BUS_SCL_BIT = 7;
   localparam int unsigned BUS_SDA_BIT = 6;
   localparam logic [7:0] BUS_ALWAYS_PULLUP = 8'h3f;
   localparam logic [7:0] SERIAL_LOW_PINS = 8'h0f;
   localparam logic [7:0] SERIAL_HIGH_PINS = 8'hf0;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic CTRL_RESET = 1'b0;
endpackage

// file: hw/sppp_port_pins.sv
// pin sharing and general-purpose i/o for the can, bus, analog, pulse, serial and timer ports
`timescale 1ns/1ps
// What this block does
// - can transmit pin: 0 dominant, 1 recessive
// - can receive on bit 0, transmit bit 1
// - can receive pins always pulled up
// - bus clock and data pins are open drain
// - disabled bus interface frees pins for gpio
// - bus clock bit 7, data bit 6
// - bus port direction bit set means output
// - bus pull-up enable; pins 0-5 always pulled
// - bus reduced drive bit, reset normal drive
// - unpowered converter leaves pins as gpio inputs
// - analog ports input only, no pad controls
// - enabled pulse channel owns its pin
// - pulse port direction bit set means output
// - pulse port pull-up bit, reset off
// - pulse port reduced drive, reset normal
// - low wire-or kills high drive pins 0-3
// - high wire-or kills high drive pins 4-7
// - serial pull-up only on gpio inputs
// - serial reduced drive weakens all pins
// - timer or accumulator enable takes timer pins
// - timer port direction bit set means output
// - timer pull-up and reduced drive, reset off
module sppp_port_pins #(
   parameter int unsigned NUM_CAN = 3,
   parameter int unsigned NUM_AD = 2,
   parameter int unsigned NUM_PULSE = 4
) (
   // system
   input wire logic ref_clk,
   input wire logic rst,
   // can ports: controller side and pins
   input wire logic [NUM_CAN-1:0] can_tx_from_ctrl,
   output logic [NUM_CAN-1:0] can_rx_to_ctrl,
   output logic [NUM_CAN-1:0] can_transmit_out,
   input wire logic [NUM_CAN-1:0] can_receive_in,
   output logic [NUM_CAN-1:0] can_receive_pullup,
   // two-wire bus port
   input wire logic bus_enable,
   input wire logic bus_scl_drive_low,
   input wire logic bus_sda_drive_low,
   output logic bus_scl_in,
   output logic bus_sda_in,
   input wire logic bus_data_wr,
   input wire logic [7:0] bus_data_wdata,
   input wire logic bus_dir_wr,
   input wire logic [7:0] bus_dir_wdata,
   input wire logic bus_pad_wr,
   input wire logic bus_pullup_wdata,
   input wire logic bus_reduced_wdata,
   output logic [7:0] bus_port_direction,
   output logic bus_port_pullup_enable,
   output logic bus_port_reduced_drive,
   output logic [7:0] bus_data_rdata,
   input wire logic [7:0] bus_pin_in,
   output logic [7:0] bus_pin_out,
   output logic [7:0] bus_pin_oe,
   output logic [7:0] bus_pin_pullup,
   output logic bus_pin_reduced,
   // analog ports
   input wire logic [NUM_AD-1:0] converter_power_up,
   input wire logic [NUM_AD-1:0][7:0] ad_pin_in,
   output logic [NUM_AD-1:0][7:0] ad_data_rdata,
   output logic [NUM_AD-1:0] ad_analog_select,
   // pulse-width port
   input wire logic [NUM_PULSE-1:0] pulse_channel_enable,
   input wire logic [NUM_PULSE-1:0] pulse_wave,
   input wire logic pulse_data_wr,
   input wire logic [NUM_PULSE-1:0] pulse_data_wdata,
   input wire logic pulse_dir_wr,
   input wire logic [NUM_PULSE-1:0] pulse_dir_wdata,
   input wire logic pulse_ctl_wr,
   input wire logic pulse_pullup_wdata,
   input wire logic pulse_reduced_wdata,
   output logic [NUM_PULSE-1:0] pulse_port_direction,
   output logic pulse_port_pullup_enable,
   output logic pulse_port_reduced_drive,
   output logic [NUM_PULSE-1:0] pulse_data_rdata,
   input wire logic [NUM_PULSE-1:0] pulse_pin_in,
   output logic [NUM_PULSE-1:0] pulse_pin_out,
   output logic [NUM_PULSE-1:0] pulse_pin_oe,
   output logic [NUM_PULSE-1:0] pulse_pin_pullup,
   output logic pulse_pin_reduced,
   // serial port
   input wire logic [7:0] serial_func_en,
   input wire logic [7:0] serial_func_oe,
   input wire logic [7:0] serial_func_out,
   input wire logic serial_wire_or_low,
   input wire logic serial_wire_or_high,
   input wire logic serial_port_pullup_enable,
   input wire logic serial_port_reduced_drive,
   input wire logic serial_data_wr,
   input wire logic [7:0] serial_data_wdata,
   input wire logic serial_dir_wr,
   input wire logic [7:0] serial_dir_wdata,
   output logic [7:0] serial_port_direction,
   output logic [7:0] serial_data_rdata,
   input wire logic [7:0] serial_pin_in,
   output logic [7:0] serial_pin_out,
   output logic [7:0] serial_pin_oe,
   output logic [7:0] serial_pin_pullup,
   output logic serial_pin_reduced,
   // timer port
   input wire logic timer_enable,
   input wire logic accumulator_enable,
   input wire logic [7:0] timer_func_oe,
   input wire logic [7:0] timer_func_out,
   input wire logic timer_data_wr,
   input wire logic [7:0] timer_data_wdata,
   input wire logic timer_dir_wr,
   input wire logic [7:0] timer_dir_wdata,
   input wire logic timer_ctl_wr,
   input wire logic timer_pullup_wdata,
   input wire logic timer_reduced_wdata,
   output logic [7:0] timer_port_direction,
   output logic timer_port_pullup_enable,
   output logic timer_port_reduced_drive,
   output logic [7:0] timer_data_rdata,
   input wire logic [7:0] timer_pin_in,
   output logic [7:0] timer_pin_out,
   output logic [7:0] timer_pin_oe,
   output logic [7:0] timer_pin_pullup,
   output logic timer_pin_reduced
);

   // refuse counts the 8-bit port logic cannot serve
   if (NUM_CAN < 1 || NUM_AD < 1 || NUM_PULSE < 1 || NUM_PULSE > 8) begin : g_bad_counts
      $error("sppp_port_pins: unsupported port counts");
   end

   logic [7:0] bus_latch;
   logic [NUM_PULSE-1:0] pulse_latch;
   logic [7:0] serial_latch;
   logic [7:0] timer_latch;
   logic timer_taken;

   // merge pin level and latch by direction
   function automatic logic [7:0] sppp_readback(input logic [7:0] dir, input logic [7:0] latch,
                                                input logic [7:0] pin);
      sppp_readback = (dir & latch) | (~dir & pin);
   endfunction

   // can: straight wiring, controller owns both pins
   always_comb begin
      can_transmit_out = can_tx_from_ctrl;
      can_rx_to_ctrl = can_receive_in;
      can_receive_pullup = '1;
   end

   // bus port registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_port_direction <= sppp_pkg::DIR_RESET;
         bus_latch <= sppp_pkg::DATA_RESET;
      end else begin
         if (bus_dir_wr) begin
            bus_port_direction <= bus_dir_wdata;
         end
         if (bus_data_wr) begin
            bus_latch <= bus_data_wdata;
         end
      end
   end

   // pad control register readable and writable at any time
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_port_pullup_enable <= sppp_pkg::CTRL_RESET;
         bus_port_reduced_drive <= sppp_pkg::CTRL_RESET;
      end else if (bus_pad_wr) begin
         bus_port_pullup_enable <= bus_pullup_wdata;
         bus_port_reduced_drive <= bus_reduced_wdata;
      end
   end

   always_comb begin
      bus_pin_out = bus_latch;
      bus_pin_oe = bus_port_direction;
      if (bus_enable) begin
         // open drain: only ever pull low, never drive high
         bus_pin_out[sppp_pkg::BUS_SCL_BIT] = 1'b0;
         bus_pin_out[sppp_pkg::BUS_SDA_BIT] = 1'b0;
         bus_pin_oe[sppp_pkg::BUS_SCL_BIT] = bus_scl_drive_low;
         bus_pin_oe[sppp_pkg::BUS_SDA_BIT] = bus_sda_drive_low;
      end
      bus_pin_pullup = (~bus_pin_oe & {8{bus_port_pullup_enable}}) | sppp_pkg::BUS_ALWAYS_PULLUP;
      bus_pin_reduced = bus_port_reduced_drive;
      bus_scl_in = bus_pin_in[sppp_pkg::BUS_SCL_BIT];
      bus_sda_in = bus_pin_in[sppp_pkg::BUS_SDA_BIT];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_data_rdata <= sppp_pkg::DATA_RESET;
      end else begin
         bus_data_rdata <= sppp_readback(bus_port_direction, bus_latch, bus_pin_in);
      end
   end

   // analog ports: no direction, pulls or drive control exist here
   genvar gi;
   generate
      for (gi = 0; gi < NUM_AD; gi++) begin : g_ad
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               ad_data_rdata[gi] <= sppp_pkg::DATA_RESET;
            end else begin
               ad_data_rdata[gi] <= ad_pin_in[gi];
            end
         end
         assign ad_analog_select[gi] = converter_power_up[gi];
      end
   endgenerate

   // pulse port
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_port_direction <= sppp_pkg::DIR_RESET[NUM_PULSE-1:0];
         pulse_latch <= sppp_pkg::DATA_RESET[NUM_PULSE-1:0];
      end else begin
         if (pulse_dir_wr) begin
            pulse_port_direction <= pulse_dir_wdata;
         end
         if (pulse_data_wr) begin
            pulse_latch <= pulse_data_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_port_pullup_enable <= sppp_pkg::CTRL_RESET;
         pulse_port_reduced_drive <= sppp_pkg::CTRL_RESET;
      end else if (pulse_ctl_wr) begin
         pulse_port_pullup_enable <= pulse_pullup_wdata;
         pulse_port_reduced_drive <= pulse_reduced_wdata;
      end
   end

   always_comb begin
      // channel enable wins over the port, bit by bit
      pulse_pin_out = (pulse_channel_enable & pulse_wave) | (~pulse_channel_enable & pulse_latch);
      pulse_pin_oe = pulse_channel_enable | pulse_port_direction;
      pulse_pin_pullup = ~pulse_pin_oe & {NUM_PULSE{pulse_port_pullup_enable}};
      pulse_pin_reduced = pulse_port_reduced_drive;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_data_rdata <= sppp_pkg::DATA_RESET[NUM_PULSE-1:0];
      end else begin
         pulse_data_rdata <= (pulse_port_direction & pulse_latch) | (~pulse_port_direction & pulse_pin_in);
      end
   end

   // serial port
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_port_direction <= sppp_pkg::DIR_RESET;
         serial_latch <= sppp_pkg::DATA_RESET;
      end else begin
         if (serial_dir_wr) begin
            serial_port_direction <= serial_dir_wdata;
         end
         if (serial_data_wr) begin
            serial_latch <= serial_data_wdata;
         end
      end
   end

   logic [7:0] serial_level;
   logic [7:0] serial_drive;
   logic [7:0] serial_wired;
   always_comb begin
      serial_level = (serial_func_en & serial_func_out) | (~serial_func_en & serial_latch);
      serial_drive = (serial_func_en & serial_func_oe) | (~serial_func_en & serial_port_direction);
      serial_wired = ({8{serial_wire_or_low}} & sppp_pkg::SERIAL_LOW_PINS)
                   | ({8{serial_wire_or_high}} & sppp_pkg::SERIAL_HIGH_PINS);
      // wire-or: a high level releases the pin instead of driving it
      serial_pin_out = serial_level;
      serial_pin_oe = serial_drive & ~(serial_wired & serial_level);
      serial_pin_pullup = ~serial_func_en & ~serial_port_direction & {8{serial_port_pullup_enable}};
      serial_pin_reduced = serial_port_reduced_drive;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_data_rdata <= sppp_pkg::DATA_RESET;
      end else begin
         serial_data_rdata <= sppp_readback(serial_port_direction, serial_latch, serial_pin_in);
      end
   end

   // timer port
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timer_port_direction <= sppp_pkg::DIR_RESET;
         timer_latch <= sppp_pkg::DATA_RESET;
      end else begin
         if (timer_dir_wr) begin
            timer_port_direction <= timer_dir_wdata;
         end
         if (timer_data_wr) begin
            timer_latch <= timer_data_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timer_port_pullup_enable <= sppp_pkg::CTRL_RESET;
         timer_port_reduced_drive <= sppp_pkg::CTRL_RESET;
      end else if (timer_ctl_wr) begin
         timer_port_pullup_enable <= timer_pullup_wdata;
         timer_port_reduced_drive <= timer_reduced_wdata;
      end
   end

   always_comb begin
      timer_taken = timer_enable | accumulator_enable;
      timer_pin_out = timer_taken ? timer_func_out : timer_latch;
      timer_pin_oe = timer_taken ? timer_func_oe : timer_port_direction;
      timer_pin_pullup = ~timer_pin_oe & {8{timer_port_pullup_enable}};
      timer_pin_reduced = timer_port_reduced_drive;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timer_data_rdata <= sppp_pkg::DATA_RESET;
      end else begin
         timer_data_rdata <= sppp_readback(timer_port_direction, timer_latch, timer_pin_in);
      end
   end

endmodule

// file: tb/sppp_pad_model.sv
// pad model: resolves each pin from block drive, pull-up and outside drive
`timescale 1ns/1ps
module sppp_pad_model #(parameter int unsigned W = 8) (
   // block side
   input wire logic ref_clk,
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] pin_pullup,
   // outside
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin_level
);
   logic [W-1:0] pat = '0;
   // a floating pin toggles so a stale value cannot read as a match
   always @(posedge ref_clk) pat <= ~pat;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | pat[i];
      end
   end
endmodule

// file: tb/sppp_port_pins_sva.sv
// checker on the port pin block's ports
`timescale 1ns/1ps
module sppp_port_pins_sva #(parameter int unsigned NUM_CAN = 3, NUM_AD = 2, NUM_PULSE = 4) (
   // system
   input wire logic ref_clk,
   input wire logic rst,
   // can
   input wire logic [NUM_CAN-1:0] can_tx_from_ctrl,
   input wire logic [NUM_CAN-1:0] can_transmit_out,
   input wire logic [NUM_CAN-1:0] can_receive_in,
   input wire logic [NUM_CAN-1:0] can_rx_to_ctrl,
   // bus
   input wire logic bus_enable,
   input wire logic bus_scl_drive_low,
   input wire logic bus_sda_drive_low,
   input wire logic bus_dir_wr,
   input wire logic [7:0] bus_dir_wdata,
   input wire logic [7:0] bus_port_direction,
   input wire logic [7:0] bus_pin_out,
   input wire logic [7:0] bus_pin_oe,
   input wire logic [7:0] bus_pin_pullup,
   // analog, pulse, serial
   input wire logic [NUM_AD-1:0][7:0] ad_pin_in,
   input wire logic [NUM_AD-1:0][7:0] ad_data_rdata,
   input wire logic [NUM_PULSE-1:0] pulse_channel_enable,
   input wire logic [NUM_PULSE-1:0] pulse_port_direction,
   input wire logic [NUM_PULSE-1:0] pulse_pin_oe,
   input wire logic serial_wire_or_low,
   input wire logic serial_wire_or_high,
   input wire logic [7:0] serial_pin_out,
   input wire logic [7:0] serial_pin_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_can; can_transmit_out == can_tx_from_ctrl && can_rx_to_ctrl == can_receive_in; endproperty
   a_can: assert property (p_can) else $error("can pin mismatch");
   property p_dir; bus_dir_wr && !bus_enable |=> bus_enable ||
      (bus_port_direction == $past(bus_dir_wdata) && bus_pin_oe == $past(bus_dir_wdata)); endproperty
   a_dir: assert property (p_dir) else $error("bus direction write lost");
   property p_od; bus_enable |-> bus_pin_out[7:6] == 2'h0 &&
      bus_pin_oe[7:6] == {bus_scl_drive_low, bus_sda_drive_low}; endproperty
   a_od: assert property (p_od) else $error("bus pins not open drain");
   property p_pu; bus_pin_pullup[5:0] == 6'h3f; endproperty
   a_pu: assert property (p_pu) else $error("bus low pins lost pull-up");
   property p_ad; !$past(rst) |-> ad_data_rdata == $past(ad_pin_in); endproperty
   a_ad: assert property (p_ad) else $error("analog read wrong");
   property p_pw; pulse_pin_oe == (pulse_channel_enable | pulse_port_direction); endproperty
   a_pw: assert property (p_pw) else $error("pulse pin ownership wrong");
   property p_wl; serial_wire_or_low |-> (serial_pin_oe[3:0] & serial_pin_out[3:0]) == 4'h0; endproperty
   a_wl: assert property (p_wl) else $error("low serial pins drive high");
   property p_wh; serial_wire_or_high |-> (serial_pin_oe[7:4] & serial_pin_out[7:4]) == 4'h0; endproperty
   a_wh: assert property (p_wh) else $error("high serial pins drive high");
   c_bus: cover property (bus_enable && bus_scl_drive_low);
   c_wor: cover property (serial_wire_or_low);
   c_pw: cover property (pulse_channel_enable != '0);
endmodule
bind sppp_port_pins sppp_port_pins_sva #(.NUM_CAN(NUM_CAN), .NUM_AD(NUM_AD), .NUM_PULSE(NUM_PULSE)) u_sva (.*);

// file: tb/sppp_port_pins_tb.sv
// self-checking bench for the port pin block
`timescale 1ns/1ps
module sppp_port_pins_tb;
   logic ref_clk = 0, rst = 1, bus_enable = 0, bus_scl_drive_low = 0, bus_sda_drive_low = 0, bus_data_wr = 0;
   logic bus_dir_wr = 0, bus_pad_wr = 0, bus_pullup_wdata = 0, bus_reduced_wdata = 0, pulse_data_wr = 0;
   logic pulse_dir_wr = 0, pulse_ctl_wr = 0, pulse_pullup_wdata = 0, pulse_reduced_wdata = 0;
   logic serial_wire_or_low = 0, serial_wire_or_high = 0, serial_port_pullup_enable = 0, serial_data_wr = 0;
   logic serial_port_reduced_drive = 0, serial_dir_wr = 0, timer_enable = 0, accumulator_enable = 0;
   logic timer_data_wr = 0, timer_dir_wr = 0, timer_ctl_wr = 0, timer_pullup_wdata = 0, timer_reduced_wdata = 0;
   logic bus_scl_in, bus_sda_in, bus_port_pullup_enable, bus_port_reduced_drive, bus_pin_reduced;
   logic pulse_port_pullup_enable, pulse_port_reduced_drive, pulse_pin_reduced, serial_pin_reduced;
   logic timer_port_pullup_enable, timer_port_reduced_drive, timer_pin_reduced;
   logic [2:0] can_tx_from_ctrl = 0, can_receive_in = 0, can_rx_to_ctrl, can_transmit_out, can_receive_pullup;
   logic [1:0] converter_power_up = 0, ad_analog_select;
   logic [1:0][7:0] ad_pin_in = 0, ad_data_rdata;
   logic [3:0] pulse_channel_enable = 0, pulse_wave = 0, pulse_data_wdata = 0, pulse_dir_wdata = 0, pulse_pin_in = 0;
   logic [3:0] pulse_port_direction, pulse_data_rdata, pulse_pin_out, pulse_pin_oe, pulse_pin_pullup;
   logic [7:0] bus_data_wdata = 0, bus_dir_wdata = 0, bus_ext_en = 0, serial_func_en = 0, serial_func_oe = 0;
   logic [7:0] serial_func_out = 0, serial_data_wdata = 0, serial_dir_wdata = 0, serial_pin_in = 0;
   logic [7:0] timer_func_oe = 0, timer_func_out = 0, timer_data_wdata = 0, timer_dir_wdata = 0, timer_pin_in = 0;
   logic [7:0] bus_port_direction, bus_data_rdata, bus_pin_in, bus_pin_out, bus_pin_oe, bus_pin_pullup;
   logic [7:0] serial_port_direction, serial_data_rdata, serial_pin_out, serial_pin_oe, serial_pin_pullup;
   logic [7:0] timer_port_direction, timer_data_rdata, timer_pin_out, timer_pin_oe, timer_pin_pullup;
   int bad_count = 0, total_checks = 0;

   sppp_port_pins u_dut (.*);
   sppp_pad_model u_bus_pad (.ref_clk(ref_clk), .pin_out(bus_pin_out), .pin_oe(bus_pin_oe),
      .pin_pullup(bus_pin_pullup), .ext_en(bus_ext_en), .ext_val(8'h00), .pin_level(bus_pin_in));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic step;
      @(posedge ref_clk);
      #10;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one strobe per call, then an idle edge so the same strobe never toggles twice at once
   task automatic wr(input int k, input logic [7:0] d);
      case (k)
         0: begin bus_dir_wr = 1; bus_dir_wdata = d; end
         1: begin bus_data_wr = 1; bus_data_wdata = d; end
         2: begin bus_pad_wr = 1; {bus_reduced_wdata, bus_pullup_wdata} = d[1:0]; end
         3: begin pulse_dir_wr = 1; pulse_dir_wdata = d[3:0]; end
         4: begin pulse_data_wr = 1; pulse_data_wdata = d[3:0]; end
         5: begin pulse_ctl_wr = 1; {pulse_reduced_wdata, pulse_pullup_wdata} = d[1:0]; end
         6: begin serial_dir_wr = 1; serial_dir_wdata = d; end
         7: begin serial_data_wr = 1; serial_data_wdata = d; end
         8: begin timer_dir_wr = 1; timer_dir_wdata = d; end
         9: begin timer_data_wr = 1; timer_data_wdata = d; end
         default: begin timer_ctl_wr = 1; {timer_reduced_wdata, timer_pullup_wdata} = d[1:0]; end
      endcase
      step();
      {bus_dir_wr, bus_data_wr, bus_pad_wr, pulse_dir_wr, pulse_data_wr, pulse_ctl_wr} = '0;
      {serial_dir_wr, serial_data_wr, timer_dir_wr, timer_data_wr, timer_ctl_wr} = '0;
      step();
   endtask

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      #10 rst = 0;
      step();
      check({bus_port_direction | timer_port_direction}, 8'h00);
      check(pulse_port_direction, 8'h00);
      check({bus_port_pullup_enable, bus_port_reduced_drive, pulse_port_pullup_enable}, 8'h00);
      check({pulse_port_reduced_drive, timer_port_pullup_enable, timer_port_reduced_drive}, 8'h00);
      check(bus_pin_pullup, 8'h3f);
      check(can_receive_pullup, 8'h07);
      $display("test reset done");
      can_tx_from_ctrl = 3'h5;
      can_receive_in = 3'h3;
      step();
      check(can_transmit_out, 8'h05);
      check(can_rx_to_ctrl, 8'h03);
      $display("test can done");
      bus_ext_en = 8'h40;
      wr(0, 8'h80);
      wr(1, 8'h80);
      check(bus_pin_oe, 8'h80);
      check(bus_pin_out & 8'h80, 8'h80);
      check(bus_data_rdata, 8'hbf);
      wr(2, 8'h03);
      check(bus_pin_pullup, 8'h7f);
      check(bus_pin_reduced, 8'h01);
      bus_enable = 1;
      bus_scl_drive_low = 1;
      step();
      check(bus_pin_oe & 8'hc0, 8'h80);
      check(bus_pin_out & 8'hc0, 8'h00);
      check({bus_scl_in, bus_sda_in}, 8'h00);
      bus_scl_drive_low = 0;
      bus_sda_drive_low = 1;
      step();
      check(bus_pin_oe & 8'hc0, 8'h40);
      check({bus_scl_in, bus_sda_in}, 8'h02);
      bus_sda_drive_low = 0;
      $display("test bus done");
      ad_pin_in = 16'h5aa5;
      converter_power_up = 2'h1;
      step();
      step();
      check(ad_data_rdata[0], 8'ha5);
      check(ad_data_rdata[1], 8'h5a);
      check(ad_analog_select, 8'h01);
      $display("test analog done");
      pulse_pin_in = 4'ha;
      wr(3, 8'h03);
      wr(4, 8'h01);
      check(pulse_data_rdata, 8'h09);
      pulse_channel_enable = 4'h4;
      pulse_wave = 4'h4;
      wr(5, 8'h03);
      check(pulse_pin_oe, 8'h07);
      check(pulse_pin_out, 8'h05);
      check(pulse_pin_pullup, 8'h08);
      check(pulse_pin_reduced, 8'h01);
      $display("test pulse done");
      wr(6, 8'hff);
      wr(7, 8'hff);
      serial_wire_or_low = 1;
      step();
      check(serial_pin_oe, 8'hf0);
      serial_wire_or_low = 0;
      serial_wire_or_high = 1;
      step();
      check(serial_pin_oe, 8'h0f);
      serial_wire_or_high = 0;
      serial_port_pullup_enable = 1;
      serial_port_reduced_drive = 1;
      wr(6, 8'h0f);
      check(serial_pin_pullup, 8'hf0);
      check(serial_pin_reduced, 8'h01);
      check(serial_port_direction, 8'h0f);
      check(serial_data_rdata, 8'h0f);
      serial_func_en = 8'h03;
      serial_func_oe = 8'h03;
      serial_func_out = 8'h01;
      serial_wire_or_low = 1;
      step();
      check(serial_pin_oe, 8'h02);
      check(serial_pin_out, 8'hfd);
      check(serial_pin_pullup, 8'hf0);
      {serial_func_en, serial_wire_or_low} = '0;
      $display("test serial done");
      wr(8, 8'hff);
      wr(9, 8'ha5);
      check(timer_pin_out & timer_pin_oe, 8'ha5);
      check(timer_data_rdata, 8'ha5);
      timer_func_out = 8'h3c;
      timer_func_oe = 8'h0f;
      timer_enable = 1;
      step();
      check(timer_pin_out, 8'h3c);
      timer_enable = 0;
      accumulator_enable = 1;
      step();
      check(timer_pin_oe, 8'h0f);
      accumulator_enable = 0;
      wr(8, 8'h00);
      wr(10, 8'h03);
      check(timer_pin_pullup, 8'hff);
      check(timer_pin_reduced, 8'h01);
      $display("test timer done");
      // reset again after every control has been written
      rst = 1;
      step();
      rst = 0;
      step();
      check(bus_port_direction | {4'h0, pulse_port_direction}, 8'h00);
      check({bus_port_pullup_enable, bus_port_reduced_drive, pulse_port_pullup_enable}, 8'h00);
      check({pulse_port_reduced_drive, timer_port_pullup_enable, timer_port_reduced_drive}, 8'h00);
      check(bus_pin_pullup, 8'h3f);
      $display("test reset again done");
      report_and_stop();
   end
endmodule
